// ==== rtl/vfi_pkg.sv ====
// Function
// - 720p codes 00h-09h, even native, odd extended
// - 1080 2200/2376 and 1035 rasters coded
// - 1080/25 2640-sample rasters coded 0Ch-0Fh
// - 1080/24 2750-sample rasters coded 10h-13h
// - 525 and 625 line rasters coded
// - Unmatched HD 1Dh, SD 1Eh, never 1Ch/1Fh
// - HD rate without ASI fills luma and chroma formats
// - SD or ASI: luma only, chroma all ones
// - Formats all ones on reset, unlock, pass-through
// - Format codes 0h to 3h tape, packages
// - Format codes 4h-8h, Fh unknown
// - Standard code in status bits 14:10
// - Standard code zero on reset, unlock, bypass
package vfi_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // Register offsets
  localparam logic [7:0] VID_STD_ADDR  = 8'h04;
  localparam logic [7:0] CTRL_ADDR     = 8'h20;
  localparam logic [7:0] TRACK_ADDR    = 8'h21;

  // Status word field positions
  localparam int STD_MSB   = 14;
  localparam int STD_LSB   = 10;
  localparam int INTP_BIT  = 9;
  localparam int SLOCK_BIT = 8;
  localparam int CFMT_LSB  = 4;
  localparam int YFMT_LSB  = 0;

  // Control word fields and reset values
  localparam int DT_BIT      = 0;
  localparam int CONF_LSB    = 1;
  localparam int CONF_W      = 3;
  localparam logic [2:0] CONF_RST = 3'h2;

  // Standard codes
  localparam logic [4:0] STD_CLEAR   = 5'h00;
  localparam logic [4:0] STD_1080I60 = 5'h0a;
  localparam logic [4:0] STD_1080P30 = 5'h0b;
  localparam logic [4:0] STD_1080I50 = 5'h0c;
  localparam logic [4:0] STD_1080P25 = 5'h0d;
  localparam logic [4:0] STD_P25_EM  = 5'h0e;
  localparam logic [4:0] STD_SF25_EM = 5'h0f;
  localparam logic [4:0] STD_1080P24 = 5'h10;
  localparam logic [4:0] STD_SF24    = 5'h11;
  localparam logic [4:0] STD_ALT50   = 5'h14;
  localparam logic [4:0] STD_1035I   = 5'h15;
  localparam logic [4:0] STD_525_487 = 5'h16;
  localparam logic [4:0] STD_525_507 = 5'h17;
  localparam logic [4:0] STD_625     = 5'h18;
  localparam logic [4:0] STD_525_G87 = 5'h19;
  localparam logic [4:0] STD_625_GEN = 5'h1a;
  localparam logic [4:0] STD_525_G07 = 5'h1b;
  localparam logic [4:0] STD_UNK_HD  = 5'h1d;
  localparam logic [4:0] STD_UNK_SD  = 5'h1e;

  // Data format codes
  localparam logic [3:0] FMT_TAPE_NO_ECC = 4'h0;
  localparam logic [3:0] FMT_TAPE_ECC    = 4'h1;
  localparam logic [3:0] FMT_TAPE2       = 4'h2;
  localparam logic [3:0] FMT_CONTENT_PKG = 4'h3;
  localparam logic [3:0] FMT_FIXED_BLK   = 4'h4;
  localparam logic [3:0] FMT_VAR_BLK     = 4'h5;
  localparam logic [3:0] FMT_SDI         = 4'h6;
  localparam logic [3:0] FMT_ASI         = 4'h7;
  localparam logic [3:0] FMT_TDM         = 4'h8;
  localparam logic [3:0] FMT_UNKNOWN     = 4'hf;

  // Raster figures
  localparam logic [12:0] TS_720_60  = 13'd1650;
  localparam logic [12:0] TS_720_30  = 13'd3300;
  localparam logic [12:0] TS_720_50  = 13'd1980;
  localparam logic [12:0] TS_720_25  = 13'd3960;
  localparam logic [12:0] TS_720_24  = 13'd4125;
  localparam logic [12:0] TS_1080_60 = 13'd2200;
  localparam logic [12:0] TS_1080_50 = 13'd2640;
  localparam logic [12:0] TS_1080_24 = 13'd2750;
  localparam logic [12:0] TS_ALT50   = 13'd2376;
  localparam logic [12:0] TS_525     = 13'd1716;
  localparam logic [12:0] TS_625     = 13'd1728;
  localparam logic [12:0] AS_720     = 13'd1280;
  localparam logic [12:0] AS_1080    = 13'd1920;
  localparam logic [12:0] AS_SD      = 13'd1440;
  localparam logic [10:0] TL_720     = 11'd750;
  localparam logic [10:0] TL_1125    = 11'd1125;
  localparam logic [10:0] TL_1250    = 11'd1250;
  localparam logic [10:0] TL_525     = 11'd525;
  localparam logic [10:0] TL_625     = 11'd625;
  localparam logic [10:0] AL_1035    = 11'd517;
  localparam logic [10:0] AL_487     = 11'd244;
  localparam logic [10:0] AL_507     = 11'd254;

  // One measured raster, valid once per frame
  typedef struct packed {
    logic [12:0] total_samples;
    logic [12:0] active_samples;
    logic [10:0] total_lines;
    logic [10:0] active_lines;
    logic        interlaced;
  } raster_type;

  // Payload identifier format codes
  typedef struct packed {
    logic       valid;
    logic [3:0] luma;
    logic [3:0] chroma;
  } payload_fmt_type;

endpackage

// ==== rtl/raster_matcher.sv ====
`timescale 1ns/1ns
module raster_matcher
  import vfi_pkg::*;
(
  input  raster_type raster_i,
  input  wire logic  hd_i,
  output logic [4:0] code_o
);

  wire logic [12:0] ts = raster_i.total_samples;
  wire logic        nat = (raster_i.active_samples == AS_1080);
  wire logic        il  = raster_i.interlaced;
  wire logic        l1125 = (raster_i.total_lines == TL_1125);

  // Pick odd extended code when active width is not native
  function automatic logic [4:0] pair(input logic [4:0] base, input logic native);
    pair = native ? base : base + 5'h01;
  endfunction

  // Lookup keyed on total samples per line
  always_comb begin
    code_o = hd_i ? STD_UNK_HD : STD_UNK_SD;
    if (hd_i && raster_i.total_lines == TL_720) begin
      case (ts)
        TS_720_60: code_o = pair(5'h00, raster_i.active_samples == AS_720);
        TS_720_30: code_o = pair(5'h02, raster_i.active_samples == AS_720);
        TS_720_50: code_o = pair(5'h04, raster_i.active_samples == AS_720);
        TS_720_25: code_o = pair(5'h06, raster_i.active_samples == AS_720);
        TS_720_24: code_o = pair(5'h08, raster_i.active_samples == AS_720);
        default:   code_o = STD_UNK_HD;
      endcase
    end else if (hd_i && l1125) begin
      case (ts)
        TS_1080_60: begin
          if (raster_i.active_lines == AL_1035) code_o = STD_1035I;
          else code_o = il ? STD_1080I60 : STD_1080P30;
        end
        TS_1080_50: begin
          if (nat) code_o = il ? STD_1080I50 : STD_1080P25;
          else code_o = il ? STD_SF25_EM : STD_P25_EM;
        end
        TS_1080_24: code_o = pair(il ? STD_SF24 : STD_1080P24, 1'b1) + (nat ? 5'h00 : 5'h02);
        default:    code_o = STD_UNK_HD;
      endcase
    end else if (hd_i && raster_i.total_lines == TL_1250 && ts == TS_ALT50) begin
      code_o = STD_ALT50;
    end else if (!hd_i && ts == TS_525 && raster_i.total_lines == TL_525) begin
      if (raster_i.active_samples == AS_SD)
        code_o = (raster_i.active_lines == AL_507) ? STD_525_507 : STD_525_487;
      else
        code_o = (raster_i.active_lines == AL_507) ? STD_525_G07 : STD_525_G87;
    end else if (!hd_i && ts == TS_625 && raster_i.total_lines == TL_625) begin
      code_o = (raster_i.active_samples == AS_SD) ? STD_625 : STD_625_GEN;
    end
  end

endmodule

// ==== rtl/video_format_indicator.sv ====
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ns
module video_format_indicator
  import vfi_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic              rst_i,
  // Timing extraction
  input  raster_type             raster_i,
  input  wire logic              raster_valid_i,
  input  wire logic              std_lock_i,
  input  wire logic              locked_i,
  input  wire logic              rate_indicator_i,
  input  wire logic              asi_mode_i,
  input  payload_fmt_type        payload_fmt_i,
  // Pin from outside the clock domain
  input  wire logic              processing_bypass_n_i,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  input  wire logic              reg_we_i,
  input  wire logic              reg_re_i,
  output logic      [DATA_W-1:0] reg_rdata_o,
  // Direct status outputs
  output logic      [4:0]        video_standard_code_o,
  output logic      [3:0]        luma_format_code_o,
  output logic      [3:0]        chroma_format_code_o,
  output logic                   data_through_o
);

  // Classifier FSM states
  typedef enum logic [2:0] {
    ST_BLANK   = 3'b001,
    ST_CONFIRM = 3'b010,
    ST_REPORT  = 3'b100
  } track_state_type;

  track_state_type state_r;
  track_state_type state_nxt;

  logic [4:0]        std_code_r;
  logic [4:0]        std_code_nxt;
  logic              int_prog_r;
  logic              int_prog_nxt;
  logic [4:0]        cand_r;
  logic [4:0]        cand_nxt;
  logic [CONF_W-1:0] match_cnt_r;
  logic [CONF_W-1:0] match_cnt_nxt;
  logic [3:0]        luma_fmt_r;
  logic [3:0]        luma_fmt_nxt;
  logic [3:0]        chroma_fmt_r;
  logic [3:0]        chroma_fmt_nxt;
  logic              data_through_r;
  logic [CONF_W-1:0] confirm_r;
  logic [DATA_W-1:0] rdata_r;
  logic [2:0]        bypass_sync_r;
  logic              bypass_n_r;

  wire logic [4:0]        match_code;
  wire logic              hd_mode;
  wire logic              lock_lost;
  wire logic              std_clear;
  wire logic              fmt_clear;
  wire logic              same_cand;
  wire logic [CONF_W-1:0] cnt_inc;
  wire logic              confirmed;
  wire logic [CONF_W-1:0] confirm_eff;
  wire logic              ctrl_wr;
  wire logic [DATA_W-1:0] std_word;
  wire logic [DATA_W-1:0] ctrl_word;
  wire logic [DATA_W-1:0] track_word;
  wire logic [DATA_W-1:0] read_mux;
  wire logic [3:0]        luma_src;
  wire logic [3:0]        chroma_src;

  // Saturating increment shared by the match counter
  function automatic logic [CONF_W-1:0] sat_inc(input logic [CONF_W-1:0] v);
    sat_inc = (v == {CONF_W{1'b1}}) ? v : v + {{(CONF_W-1){1'b0}}, 1'b1};
  endfunction

  // Keep reserved format codes out of the fields
  function automatic logic [3:0] fmt_filter(input logic [3:0] f);
    fmt_filter = (f > FMT_TDM) ? FMT_UNKNOWN : f;
  endfunction

  // Bypass pin: three stages, a change counts once
  // the second and third agree
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      bypass_sync_r <= 3'h7;
    end else begin
      bypass_sync_r <= {bypass_sync_r[1:0], processing_bypass_n_i};
    end
  end

  // Filtered bypass level
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      bypass_n_r <= 1'b1;
    end else if (bypass_sync_r[1] == bypass_sync_r[2]) begin
      bypass_n_r <= bypass_sync_r[2];
    end
  end

  // Table lookup of the current measurement
  raster_matcher u_matcher (
    .raster_i (raster_i),
    .hd_i     (hd_mode),
    .code_o   (match_code)
  );

  // Mode and clearing conditions
  assign hd_mode   = !rate_indicator_i;
  assign lock_lost = !locked_i;
  assign std_clear = lock_lost || !bypass_n_r;
  assign fmt_clear = lock_lost || data_through_r;

  // A zero threshold would confirm on the second match, so treat it as one
  assign confirm_eff = (confirm_r == {CONF_W{1'b0}}) ?
                       {{(CONF_W-1){1'b0}}, 1'b1} : confirm_r;
  assign same_cand   = (match_code == cand_r);
  assign cnt_inc     = sat_inc(match_cnt_r);
  assign confirmed   = (cnt_inc >= confirm_eff);

  // Classifier: a new code needs a run of equal matches
  always_comb begin
    state_nxt     = state_r;
    std_code_nxt  = std_code_r;
    int_prog_nxt  = int_prog_r;
    cand_nxt      = cand_r;
    match_cnt_nxt = match_cnt_r;
    case (state_r)
      ST_BLANK: begin
        if (raster_valid_i) begin
          cand_nxt      = match_code;
          match_cnt_nxt = {{(CONF_W-1){1'b0}}, 1'b1};
          if (confirm_eff == {{(CONF_W-1){1'b0}}, 1'b1}) begin
            std_code_nxt = match_code;
            int_prog_nxt = raster_i.interlaced;
            state_nxt    = ST_REPORT;
          end else begin
            state_nxt = ST_CONFIRM;
          end
        end
      end
      ST_CONFIRM: begin
        if (raster_valid_i) begin
          if (same_cand) begin
            match_cnt_nxt = cnt_inc;
            if (confirmed) begin
              std_code_nxt = cand_r;
              int_prog_nxt = raster_i.interlaced;
              state_nxt    = ST_REPORT;
            end
          end else begin
            // Restart the run; old code stays visible
            cand_nxt      = match_code;
            match_cnt_nxt = {{(CONF_W-1){1'b0}}, 1'b1};
          end
        end
      end
      ST_REPORT: begin
        if (raster_valid_i && match_code != std_code_r) begin
          cand_nxt      = match_code;
          match_cnt_nxt = {{(CONF_W-1){1'b0}}, 1'b1};
          if (confirm_eff == {{(CONF_W-1){1'b0}}, 1'b1}) begin
            std_code_nxt = match_code;
            int_prog_nxt = raster_i.interlaced;
          end else begin
            state_nxt = ST_CONFIRM;
          end
        end
      end
      default: begin
        state_nxt     = ST_BLANK;
        std_code_nxt  = STD_CLEAR;
        match_cnt_nxt = {CONF_W{1'b0}};
      end
    endcase
    // Loss of lock or bypass wipes everything
    if (std_clear) begin
      state_nxt     = ST_BLANK;
      std_code_nxt  = STD_CLEAR;
      int_prog_nxt  = 1'b0;
      cand_nxt      = STD_CLEAR;
      match_cnt_nxt = {CONF_W{1'b0}};
    end
  end

  // Classifier registers
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_r     <= ST_BLANK;
      std_code_r  <= STD_CLEAR;
      int_prog_r  <= 1'b0;
      cand_r      <= STD_CLEAR;
      match_cnt_r <= {CONF_W{1'b0}};
    end else begin
      state_r     <= state_nxt;
      std_code_r  <= std_code_nxt;
      int_prog_r  <= int_prog_nxt;
      cand_r      <= cand_nxt;
      match_cnt_r <= match_cnt_nxt;
    end
  end

  // Format source: ASI is known from the mode alone,
  // otherwise the payload identifier, else plain serial video
  assign luma_src = asi_mode_i ? FMT_ASI :
                    payload_fmt_i.valid ? fmt_filter(payload_fmt_i.luma) :
                    FMT_SDI;
  assign chroma_src = payload_fmt_i.valid ? fmt_filter(payload_fmt_i.chroma) :
                      FMT_SDI;

  // Format fields per rate
  always_comb begin
    luma_fmt_nxt   = luma_src;
    chroma_fmt_nxt = FMT_UNKNOWN;
    if (hd_mode && !asi_mode_i) begin
      chroma_fmt_nxt = chroma_src;
    end
    if (fmt_clear) begin
      luma_fmt_nxt   = FMT_UNKNOWN;
      chroma_fmt_nxt = FMT_UNKNOWN;
    end
  end

  // Format registers
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      luma_fmt_r   <= FMT_UNKNOWN;
      chroma_fmt_r <= FMT_UNKNOWN;
    end else begin
      luma_fmt_r   <= luma_fmt_nxt;
      chroma_fmt_r <= chroma_fmt_nxt;
    end
  end

  // Control register write
  assign ctrl_wr = reg_we_i && (reg_addr_i == CTRL_ADDR);

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      data_through_r <= 1'b0;
      confirm_r      <= CONF_RST;
    end else if (ctrl_wr) begin
      data_through_r <= reg_wdata_i[DT_BIT];
      confirm_r      <= reg_wdata_i[CONF_LSB +: CONF_W];
    end
  end

  // Read words; unused bits read as zero
  assign std_word = {1'b0, std_code_r, int_prog_r,
                     std_lock_i && !std_clear,
                     chroma_fmt_r, luma_fmt_r};
  assign ctrl_word = {{(DATA_W-CONF_W-1){1'b0}}, confirm_r, data_through_r};
  assign track_word = {5'h00, state_r, match_cnt_r, cand_r};

  // Unmapped addresses read as zero
  assign read_mux = (reg_addr_i == VID_STD_ADDR) ? std_word :
                    (reg_addr_i == CTRL_ADDR)    ? ctrl_word :
                    (reg_addr_i == TRACK_ADDR)   ? track_word :
                    {DATA_W{1'b0}};

  // Read data stands one cycle only
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_r <= {DATA_W{1'b0}};
    end else if (reg_re_i) begin
      rdata_r <= read_mux;
    end else begin
      rdata_r <= {DATA_W{1'b0}};
    end
  end

  // Outputs
  assign reg_rdata_o           = rdata_r;
  assign video_standard_code_o = std_code_r;
  assign luma_format_code_o    = luma_fmt_r;
  assign chroma_format_code_o  = chroma_fmt_r;
  assign data_through_o        = data_through_r;

endmodule

// ==== testbench/vfi_checker.sv ====
`timescale 1ns/1ns
module vfi_checker
  import vfi_pkg::*;
(
  input wire logic              sys_clk_i,
  input wire logic              rst_i,
  input wire logic              raster_valid_i,
  input wire logic              locked_i,
  input wire logic              rate_indicator_i,
  input wire logic              asi_mode_i,
  input payload_fmt_type        payload_fmt_i,
  input wire logic              processing_bypass_n_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic              reg_we_i,
  input wire logic              reg_re_i,
  input wire logic [DATA_W-1:0] reg_rdata_o,
  input wire logic [4:0]        video_standard_code_o,
  input wire logic [3:0]        luma_format_code_o,
  input wire logic [3:0]        chroma_format_code_o,
  input wire logic              data_through_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // Formats only follow the inputs while locked and not passed through
  wire fmt_live = locked_i && !data_through_o;
  function automatic logic [3:0] map4(logic [3:0] v);
    return (v > 4'h8) ? 4'hf : v;
  endfunction
  // Bypass pin held long enough to cross the synchroniser
  sequence s_bypass_held;
    !processing_bypass_n_i [*5];
  endsequence
  sequence s_hd_payload;
    fmt_live && !rate_indicator_i && !asi_mode_i && payload_fmt_i.valid;
  endsequence
  AST_CODE_UNLOCK: assert property (!locked_i |=> video_standard_code_o == 5'h00)
    else $error("standard code not cleared on unlock");
  AST_CODE_BYPASS: assert property (s_bypass_held |=> video_standard_code_o == 5'h00)
    else $error("standard code not cleared in bypass");
  AST_FMT_CLEAR: assert property (!fmt_live |=> {luma_format_code_o, chroma_format_code_o} == 8'hff)
    else $error("formats not forced to all ones");
  AST_SD_FMT: assert property (fmt_live && (rate_indicator_i || asi_mode_i) |=> chroma_format_code_o == 4'hf)
    else $error("chroma format not all ones in sd or asi");
  AST_ASI_LUMA: assert property (fmt_live && asi_mode_i |=> luma_format_code_o == FMT_ASI)
    else $error("asi luma format wrong");
  AST_HD_FMT: assert property (s_hd_payload |=> luma_format_code_o == map4($past(payload_fmt_i.luma))
    && chroma_format_code_o == map4($past(payload_fmt_i.chroma)))
    else $error("hd formats do not follow payload");
  AST_NO_RSVD: assert property (video_standard_code_o != 5'h1c && video_standard_code_o != 5'h1f)
    else $error("reserved standard code reported");
  AST_CODE_SRC: assert property (!$stable(video_standard_code_o) && video_standard_code_o != 5'h00
    |-> $past(raster_valid_i))
    else $error("standard code changed without a measurement");
  AST_STATUS: assert property (reg_re_i && reg_addr_i == VID_STD_ADDR |=> reg_rdata_o[15:10] ==
    {1'b0, $past(video_standard_code_o)})
    else $error("status word code field wrong");
  AST_RD_IDLE: assert property (!reg_re_i |=> reg_rdata_o == 16'h0000)
    else $error("read data outside its cycle");
  AST_DT_WR: assert property (reg_we_i && reg_addr_i == CTRL_ADDR |=>
    data_through_o == $past(reg_wdata_i[DT_BIT]))
    else $error("pass-through bit not written");
endmodule
bind video_format_indicator vfi_checker chk (.*);

// ==== testbench/host_model.sv ====
`timescale 1ns/1ns
module host_model
  import vfi_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic [DATA_W-1:0] reg_rdata_i,
  output logic      [ADDR_W-1:0] reg_addr_o = 8'h00,
  output logic      [DATA_W-1:0] reg_wdata_o = 16'h0000,
  output logic                   reg_we_o = 1'b0,
  output logic                   reg_re_o = 1'b0
);
  // One-cycle write strobe beside address and data
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge sys_clk_i);
    reg_addr_o  <= a;
    reg_wdata_o <= v;
    reg_we_o    <= 1'b1;
    @(posedge sys_clk_i);
    reg_we_o <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge sys_clk_i);
    reg_addr_o <= a;
    reg_re_o   <= 1'b1;
    @(posedge sys_clk_i);
    reg_re_o <= 1'b0;
    #1;
    v = reg_rdata_i;
  endtask
endmodule

// ==== testbench/video_format_indicator_tb.sv ====
`timescale 1ns/1ns
module video_format_indicator_tb;
  import vfi_pkg::*;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  raster_type        raster = '0;
  payload_fmt_type   payload = '0;
  logic              rvalid = 1'b0;
  logic              std_lock = 1'b0;
  logic              locked = 1'b0;
  logic              rate = 1'b0;
  logic              asi = 1'b0;
  logic              bypass_n = 1'b1;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, d;
  logic              we, re, dt;
  logic [4:0]        code;
  logic [3:0]        luma, chroma;
  logic [5:0]        m_cand = 6'h3f;
  logic [4:0]        m_code = 5'h00;
  logic              m_il = 1'b0;
  logic              m_dt = 1'b0;
  int                m_cnt = 0, thr = 2, cycles = 0, miscompares = 0, n_compared = 0;
  integer            seed = 62;
  logic [12:0]       t720 [5] = '{TS_720_60, TS_720_30, TS_720_50, TS_720_25, TS_720_24};
  logic [12:0]       t1080 [3] = '{TS_1080_60, TS_1080_50, TS_1080_24};

  always #5 clk = ~clk;

  video_format_indicator uut (.sys_clk_i(clk), .rst_i(rst), .raster_i(raster),
    .raster_valid_i(rvalid), .std_lock_i(std_lock), .locked_i(locked),
    .rate_indicator_i(rate), .asi_mode_i(asi), .payload_fmt_i(payload),
    .processing_bypass_n_i(bypass_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata), .video_standard_code_o(code),
    .luma_format_code_o(luma), .chroma_format_code_o(chroma), .data_through_o(dt));
  host_model host (.sys_clk_i(clk), .reg_rdata_i(rdata), .reg_addr_o(addr),
    .reg_wdata_o(wdata), .reg_we_o(we), .reg_re_o(re));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  function automatic logic [3:0] map4(logic [3:0] v);
    return (v > 4'h8) ? FMT_UNKNOWN : v;
  endfunction

  // Reference formats; reserved payload codes read as unknown
  function automatic logic [7:0] exp_fmt();
    logic [3:0] y, c;
    y = payload.valid ? map4(payload.luma) : FMT_SDI;
    c = payload.valid ? map4(payload.chroma) : FMT_SDI;
    if (!locked || m_dt)
      return 8'hff;
    if (rate || asi)
      return {4'hf, asi ? FMT_ASI : y};
    return {c, y};
  endfunction

  // Reference classifier of one measured raster
  function automatic logic [4:0] exp_std(logic [12:0] ts, as, logic [10:0] tl, al, logic il);
    if (rate) begin
      if (ts == TS_525 && tl == TL_525)
        return (as == AS_SD) ? ((al == AL_507) ? STD_525_507 : STD_525_487)
                             : ((al == AL_507) ? STD_525_G07 : STD_525_G87);
      if (ts == TS_625 && tl == TL_625)
        return (as == AS_SD) ? STD_625 : STD_625_GEN;
      return STD_UNK_SD;
    end
    for (int k = 0; k < 5; k++)
      if (ts == t720[k] && tl == TL_720)
        return 5'(2 * k + (as != AS_720));
    if (tl == TL_1250)
      return (ts == TS_ALT50) ? STD_ALT50 : STD_UNK_HD;
    if (tl != TL_1125)
      return STD_UNK_HD;
    if (ts == TS_1080_60)
      return (al == AL_1035) ? STD_1035I : (il ? STD_1080I60 : STD_1080P30);
    if (ts == TS_1080_50)
      return (as == AS_1080) ? (il ? STD_1080I50 : STD_1080P25) : (il ? STD_SF25_EM : STD_P25_EM);
    if (ts == TS_1080_24)
      return STD_1080P24 | {3'h0, as != AS_1080, il};
    return STD_UNK_HD;
  endfunction

  // One measurement pulse; the code moves only after thr equal matches
  task automatic pulse(input logic [12:0] ts, as, input logic [10:0] tl, al, input logic il);
    logic [4:0] m;
    @(posedge clk);
    m = exp_std(ts, as, tl, al, il);
    raster <= '{ts, as, tl, al, il};
    rvalid <= 1'b1;
    @(posedge clk);
    rvalid <= 1'b0;
    m_cnt = ({1'b0, m} === m_cand) ? m_cnt + 1 : 1;
    m_cand = {1'b0, m};
    if (m_cnt >= thr) begin
      m_code = m;
      m_il = il;
    end
    @(posedge clk);
    #1;
    check(code, m_code);
  endtask

  task automatic send(input logic [12:0] ts, as, input logic [10:0] tl, al, input logic il);
    pulse(ts, as, tl, al, il);
    pulse(ts, as, tl, al, il);
  endtask

  // Control write with threshold zero counted as one
  task automatic wctl(input logic [15:0] v);
    host.wr(CTRL_ADDR, v);
    m_dt = v[DT_BIT];
    thr = (v[3:1] == 3'h0) ? 1 : v[3:1];
    #1;
    check(dt, m_dt);
  endtask

  task automatic model_clear();
    m_code = 5'h00;
    m_cand = 6'h3f;
    m_cnt = 0;
    m_il = 1'b0;
  endtask

  // Hang guard well above the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      test_done();
    end
  end

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    host.rd(VID_STD_ADDR, d);
    check(d, 16'h00ff);
    host.rd(CTRL_ADDR, d);
    check(d, 16'h0004);
    host.rd(8'h33, d);
    check(d, 16'h0000);
    host.wr(VID_STD_ADDR, 16'hffff);
    locked <= 1'b1;
    std_lock <= 1'b1;
    for (int k = 0; k < 10; k++)
      send(t720[k / 2], k[0] ? AS_1080 : AS_720, TL_720, 11'd360, 1'b0);
    for (int k = 0; k < 12; k++)
      if (k > 3 || !k[1])
        send(t1080[k / 4], k[1] ? 13'd2304 : AS_1080, TL_1125, 11'd540, k[0]);
    send(TS_1080_60, AS_1080, TL_1125, AL_1035, 1'b1);
    send(TS_ALT50, AS_1080, TL_1250, 11'd540, 1'b1);
    rate <= 1'b1;
    for (int k = 0; k < 8; k++)
      send(k[2] ? TS_625 : TS_525, k[1] ? AS_1080 : AS_SD, k[2] ? TL_625 : TL_525,
           k[0] ? AL_507 : AL_487, 1'b1);
    for (int k = 0; k < 8; k++) begin
      rate <= k[0];
      send(13'($random(seed)), AS_1080, 11'($random(seed)), 11'd540, 1'b0);
    end
    // Broken run of matches must not move the code
    rate <= 1'b0;
    send(TS_720_50, AS_720, TL_720, 11'd360, 1'b0);
    pulse(TS_1080_24, AS_1080, TL_1125, 11'd540, 1'b0);
    pulse(TS_720_60, AS_720, TL_720, 11'd360, 1'b0);
    pulse(TS_1080_24, AS_1080, TL_1125, 11'd540, 1'b0);
    wctl(16'h0006);
    send(TS_1080_50, AS_1080, TL_1125, 11'd540, 1'b1);
    pulse(TS_1080_50, AS_1080, TL_1125, 11'd540, 1'b1);
    wctl(16'h0000);
    pulse(TS_720_30, AS_720, TL_720, 11'd360, 1'b0);
    wctl(16'h0004);
    for (int k = 0; k < 16; k++) begin
      @(posedge clk);
      rate <= 1'($random(seed));
      asi <= 1'($random(seed));
      std_lock <= 1'($random(seed));
      payload <= '{k[0] | k[1], 4'(k), 4'(15 - k)};
      host.rd(VID_STD_ADDR, d);
      check(d, {1'b0, m_code, m_il, std_lock, exp_fmt()});
    end
    // Back to HD so the later raster checks land on real table entries
    rate <= 1'b0;
    wctl(16'h0005);
    repeat (2) @(posedge clk);
    #1;
    check({luma, chroma}, 8'hff);
    check(code, m_code);
    wctl(16'h0004);
    // Unlock clears everything, bypass clears only the code
    locked <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    model_clear();
    check({code, luma, chroma}, {5'h00, 8'hff});
    locked <= 1'b1;
    send(TS_720_25, AS_720, TL_720, 11'd360, 1'b0);
    bypass_n <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
    model_clear();
    check(code, 5'h00);
    check({chroma, luma}, exp_fmt());
    pulse(TS_720_25, AS_720, TL_720, 11'd360, 1'b0);
    // Bypass keeps the match run wiped, so the model forgets this pulse
    model_clear();
    bypass_n <= 1'b1;
    repeat (8) @(posedge clk);
    send(TS_720_24, AS_720, TL_720, 11'd360, 1'b0);
    // Second reset in mid-run
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    model_clear();
    m_dt = 1'b0;
    thr = 2;
    check(code, 5'h00);
    host.rd(CTRL_ADDR, d);
    check(d, 16'h0004);
    send(TS_1080_24, 13'd2400, TL_1125, 11'd540, 1'b1);
    test_done();
  end
endmodule
